// ==== verilog/psf_pkg.sv ====
// Package for the power stage event flag block: register map, field
// positions and reset values shared by the design and its bench.
// Assumes a 32-bit APB bus with byte addresses and one word per register.
package psf_pkg;

    localparam int unsigned PSF_UNITS = 3;
    localparam int unsigned PSF_ADDR_W = 8;

    // Register byte addresses
    localparam logic [7:0] PSF_ADDR_MATRIX = 8'h00;
    localparam logic [7:0] PSF_ADDR_MASK0 = 8'h04;
    localparam logic [7:0] PSF_ADDR_MASK1 = 8'h08;
    localparam logic [7:0] PSF_ADDR_MASK2 = 8'h0C;
    localparam logic [7:0] PSF_ADDR_FLAGS0 = 8'h10;
    localparam logic [7:0] PSF_ADDR_FLAGS1 = 8'h14;
    localparam logic [7:0] PSF_ADDR_FLAGS2 = 8'h18;
    localparam logic [7:0] PSF_ADDR_CTRL = 8'h1C;

    // Flag register fields; the mask register uses the same positions
    localparam int unsigned PSF_BIT_ACT_B = 7;
    localparam int unsigned PSF_BIT_ACT_A = 6;
    localparam int unsigned PSF_BIT_SYNC = 5;
    localparam int unsigned PSF_BIT_EV_B = 4;
    localparam int unsigned PSF_BIT_EV_A = 3;
    localparam int unsigned PSF_BIT_RAMP_HI = 2;
    localparam int unsigned PSF_BIT_RAMP_LO = 1;
    localparam int unsigned PSF_BIT_EOC = 0;

    // Bits that software clears by writing one
    localparam logic [7:0] PSF_FLAGS_W1C = 8'hF9;
    // Writable bits of the mask registers
    localparam logic [7:0] PSF_MASK_RW = 8'h39;

    // Matrix fields: output B levels in the upper nibble, output A lower
    localparam int unsigned PSF_MATRIX_B_LSB = 4;
    localparam int unsigned PSF_MATRIX_A_LSB = 0;

    // Control register: run bits, autorun bits, effective run state (RO)
    localparam int unsigned PSF_CTRL_RUN_LSB = 0;
    localparam int unsigned PSF_CTRL_AUTO_LSB = 3;
    localparam int unsigned PSF_CTRL_ACTIVE_LSB = 6;
    localparam logic [5:0] PSF_CTRL_RW = 6'h3F;

    // Reset values
    localparam logic [7:0] PSF_MATRIX_RESET = 8'h00;
    localparam logic [7:0] PSF_MASK_RESET = 8'h00;
    localparam logic [7:0] PSF_FLAGS_RESET = 8'h00;
    localparam logic [5:0] PSF_CTRL_RESET = 6'h00;

endpackage : psf_pkg

// ==== verilog/psf_event_flags.sv ====
// Status and interrupt flag logic for three power stage controllers, plus
// the ramp output matrix of the third controller, behind an APB slave.
// Assumes event, cycle, update, ramp and waveform inputs come from the
// waveform generators on pclk; they are used without synchronisers.
//
// Our own choices: the APB slave port and the register addresses.

module psf_event_flags
    import psf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [psf_pkg::PSF_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [psf_pkg::PSF_UNITS-1:0] wave_out_0,
    input wire logic [psf_pkg::PSF_UNITS-1:0] wave_out_1,
    input wire logic [psf_pkg::PSF_UNITS-1:0] event_a,
    input wire logic [psf_pkg::PSF_UNITS-1:0] event_b,
    input wire logic [psf_pkg::PSF_UNITS-1:0] end_cycle,
    input wire logic [psf_pkg::PSF_UNITS-1:0] update,
    input wire logic [1:0] ramp_num_0,
    input wire logic [1:0] ramp_num_1,
    input wire logic [1:0] ramp_num_2,
    output logic [psf_pkg::PSF_UNITS-1:0] unit_run,
    output logic [psf_pkg::PSF_UNITS-1:0] irq,
    output logic wave_out_a_primary,
    output logic wave_out_a_secondary,
    output logic wave_out_b_primary,
    output logic wave_out_b_secondary
);
    import psf_pkg::*;

    logic [7:0] output_ramp_matrix;
    logic [7:0] irq_mask [PSF_UNITS];
    logic [7:0] irq_flags [PSF_UNITS];
    logic [PSF_UNITS-1:0] run_bit;
    logic [PSF_UNITS-1:0] autorun_select;
    logic [PSF_UNITS-1:0] prev_out_0;
    logic [PSF_UNITS-1:0] prev_out_1;
    logic [1:0] ramp_num [PSF_UNITS];
    logic [PSF_UNITS-1:0] sync_mismatch;
    logic wr_access;
    logic rd_setup;
    logic addr_hit;
    logic [PSF_UNITS-1:0] wr_mask;
    logic [PSF_UNITS-1:0] wr_flags;
    logic wr_matrix;
    logic wr_ctrl;
    logic [31:0] next_prdata;

    assign ramp_num[0] = ramp_num_0;
    assign ramp_num[1] = ramp_num_1;
    assign ramp_num[2] = ramp_num_2;

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_access = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;

    // Only byte lane 0 carries writable register bits, so only it gates writes
    assign wr_matrix = wr_access && pstrb[0] && (paddr == PSF_ADDR_MATRIX);
    assign wr_ctrl = wr_access && pstrb[0] && (paddr == PSF_ADDR_CTRL);
    assign wr_mask[0] = wr_access && pstrb[0] && (paddr == PSF_ADDR_MASK0);
    assign wr_mask[1] = wr_access && pstrb[0] && (paddr == PSF_ADDR_MASK1);
    assign wr_mask[2] = wr_access && pstrb[0] && (paddr == PSF_ADDR_MASK2);
    assign wr_flags[0] = wr_access && pstrb[0] && (paddr == PSF_ADDR_FLAGS0);
    assign wr_flags[1] = wr_access && pstrb[0] && (paddr == PSF_ADDR_FLAGS1);
    assign wr_flags[2] = wr_access && pstrb[0] && (paddr == PSF_ADDR_FLAGS2);

    always_comb
    begin
        addr_hit = 1'b1;
        next_prdata = 32'h0000_0000;
        case (paddr)
            PSF_ADDR_MATRIX: next_prdata[7:0] = output_ramp_matrix;
            PSF_ADDR_MASK0: next_prdata[7:0] = irq_mask[0];
            PSF_ADDR_MASK1: next_prdata[7:0] = irq_mask[1];
            PSF_ADDR_MASK2: next_prdata[7:0] = irq_mask[2];
            PSF_ADDR_FLAGS0: next_prdata[7:0] = irq_flags[0];
            PSF_ADDR_FLAGS1: next_prdata[7:0] = irq_flags[1];
            PSF_ADDR_FLAGS2: next_prdata[7:0] = irq_flags[2];
            PSF_ADDR_CTRL: next_prdata[8:0] = {unit_run, autorun_select,
                                               run_bit};
            default: addr_hit = 1'b0;
        endcase
    end

    // Read data is captured at the end of the setup cycle, so it comes
    // from a flip-flop and still stands with pready in the access cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else
        begin
            prdata <= rd_setup ? next_prdata : 32'h0000_0000;
        end
    end

    assign pslverr = psel && penable && !addr_hit;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            output_ramp_matrix <= PSF_MATRIX_RESET;
        end
        else if (wr_matrix)
        begin
            output_ramp_matrix <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_bit <= PSF_CTRL_RESET[2:0];
            autorun_select <= PSF_CTRL_RESET[5:3];
        end
        else if (wr_ctrl)
        begin
            run_bit <= pwdata[PSF_CTRL_RUN_LSB +: PSF_UNITS];
            autorun_select <= pwdata[PSF_CTRL_AUTO_LSB +: PSF_UNITS];
        end
    end

    // Matrix lookup on the third unit's ramp; registered so the pins never
    // glitch while the ramp number changes.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wave_out_a_primary <= 1'b0;
            wave_out_a_secondary <= 1'b0;
            wave_out_b_primary <= 1'b0;
            wave_out_b_secondary <= 1'b0;
        end
        else
        begin
            wave_out_b_primary <=
                output_ramp_matrix[PSF_MATRIX_B_LSB + ramp_num_2];
            wave_out_b_secondary <=
                output_ramp_matrix[PSF_MATRIX_B_LSB + ramp_num_2];
            wave_out_a_primary <=
                output_ramp_matrix[PSF_MATRIX_A_LSB + ramp_num_2];
            wave_out_a_secondary <=
                output_ramp_matrix[PSF_MATRIX_A_LSB + ramp_num_2];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_out_0 <= '0;
            prev_out_1 <= '0;
        end
        else
        begin
            prev_out_0 <= wave_out_0;
            prev_out_1 <= wave_out_1;
        end
    end

    genvar u;
    generate
        for (u = 0; u < PSF_UNITS; u++)
        begin : g_unit
            localparam int unsigned PREV = (u + PSF_UNITS - 1) % PSF_UNITS;
            logic [7:0] set_bits;
            logic [7:0] clr_bits;
            logic any_event;
            logic chain_run;
            logic chain_link;

            // autorun follows predecessor
            // Walking the run bits, not unit_run, starts a whole chain on one
            // edge without a combinational loop around the ring.
            always_comb
            begin
                chain_run = run_bit[u];
                chain_link = autorun_select[u];
                for (int k = 1; k < PSF_UNITS; k++)
                begin
                    chain_run = chain_run || (chain_link &&
                        run_bit[(u + PSF_UNITS - k) % PSF_UNITS]);
                    chain_link = chain_link &&
                        autorun_select[(u + PSF_UNITS - k) % PSF_UNITS];
                end
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    unit_run[u] <= 1'b0;
                end
                else
                begin
                    unit_run[u] <= chain_run;
                end
            end

            assign sync_mismatch[u] = autorun_select[u] && unit_run[u] &&
                ((end_cycle[u] != end_cycle[PREV]) ||
                 (update[u] != update[PREV]));

            assign any_event = event_a[u] || event_b[u];

            always_comb
            begin
                set_bits = 8'h00;
                set_bits[PSF_BIT_ACT_B] = wave_out_1[u] != prev_out_1[u];
                set_bits[PSF_BIT_ACT_A] = wave_out_0[u] != prev_out_0[u];
                set_bits[PSF_BIT_SYNC] = sync_mismatch[u];
                set_bits[PSF_BIT_EV_B] = event_b[u];
                set_bits[PSF_BIT_EV_A] = event_a[u];
                set_bits[PSF_BIT_EOC] = end_cycle[u];
            end

            assign clr_bits = wr_flags[u] ? (pwdata[7:0] & PSF_FLAGS_W1C)
                                          : 8'h00;

            // A hardware set in the clearing cycle wins over the clear.
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    irq_flags[u] <= PSF_FLAGS_RESET;
                end
                else
                begin
                    irq_flags[u][7:3] <= (irq_flags[u][7:3] & ~clr_bits[7:3])
                                         | set_bits[7:3];
                    irq_flags[u][0] <= (irq_flags[u][0] & ~clr_bits[0])
                                       | set_bits[0];
                    if (any_event)
                    begin
                        irq_flags[u][PSF_BIT_RAMP_HI:PSF_BIT_RAMP_LO] <=
                            ramp_num[u];
                    end
                end
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    irq_mask[u] <= PSF_MASK_RESET;
                end
                else if (wr_mask[u])
                begin
                    irq_mask[u] <= pwdata[7:0] & PSF_MASK_RW;
                end
            end

            assign irq[u] = |(irq_flags[u] & irq_mask[u] & PSF_MASK_RW);

            a_eoc_flag_set: assert property (
                @(posedge pclk) disable iff (!presetn)
                end_cycle[u] |=> irq_flags[u][PSF_BIT_EOC])
            else $error("end of cycle flag not set");

            a_act_b_edge: assert property (
                @(posedge pclk) disable iff (!presetn)
                (wave_out_1[u] != $past(wave_out_1[u]))
                |=> irq_flags[u][PSF_BIT_ACT_B])
            else $error("output B activity flag missed");

            a_act_a_edge: assert property (
                @(posedge pclk) disable iff (!presetn)
                $changed(wave_out_0[u]) |=> irq_flags[u][PSF_BIT_ACT_A])
            else $error("output A activity flag missed");

            a_event_b_flag: assert property (
                @(posedge pclk) disable iff (!presetn)
                event_b[u] && irq_mask[u][PSF_BIT_EV_B] == 1'b0
                |=> irq_flags[u][PSF_BIT_EV_B])
            else $error("event B flag not set while disabled");

            a_event_a_irq: assert property (
                @(posedge pclk) disable iff (!presetn)
                event_a[u] && irq_mask[u][PSF_BIT_EV_A] && !wr_mask[u]
                |=> irq[u])
            else $error("event A did not raise interrupt");

            a_eoc_irq: assert property (
                @(posedge pclk) disable iff (!presetn)
                end_cycle[u] && irq_mask[u][PSF_BIT_EOC] && !wr_mask[u]
                |=> irq[u])
            else $error("end of cycle did not raise interrupt");

            a_ramp_latch: assert property (
                @(posedge pclk) disable iff (!presetn)
                (event_a[u] || event_b[u])
                |=> irq_flags[u][2:1] == $past(ramp_num[u]))
            else $error("ramp number not latched");

            a_w1c_clear: assert property (
                @(posedge pclk) disable iff (!presetn)
                wr_flags[u] && pwdata[PSF_BIT_EOC] && !end_cycle[u]
                |=> !irq_flags[u][PSF_BIT_EOC])
            else $error("end of cycle flag not cleared");

            a_w1c_keep: assert property (
                @(posedge pclk) disable iff (!presetn)
                wr_flags[u] && !pwdata[PSF_BIT_SYNC]
                && irq_flags[u][PSF_BIT_SYNC]
                |=> irq_flags[u][PSF_BIT_SYNC])
            else $error("sync flag lost on zero write");

            a_sync_err: assert property (
                @(posedge pclk) disable iff (!presetn)
                autorun_select[u] && unit_run[u]
                && (end_cycle[u] != end_cycle[PREV])
                |=> irq_flags[u][PSF_BIT_SYNC])
            else $error("sync error not flagged");

            a_sync_irq: assert property (
                @(posedge pclk) disable iff (!presetn)
                irq_flags[u][PSF_BIT_SYNC] && irq_mask[u][PSF_BIT_SYNC]
                |-> irq[u])
            else $error("sync error interrupt missing");

            a_irq_quiet: assert property (
                @(posedge pclk) disable iff (!presetn)
                wr_flags[u] && ((pwdata[7:0] & irq_mask[u]) == irq_mask[u])
                && !any_event && !end_cycle[u] && !sync_mismatch[u]
                |=> !irq[u])
            else $error("interrupt held after full clear");

            a_autorun_start: assert property (
                @(posedge pclk) disable iff (!presetn)
                $past(autorun_select[u]) && unit_run[PREV] |-> unit_run[u])
            else $error("autorun unit did not start with predecessor");
        end
    endgenerate

    a_matrix_b: assert property (
        @(posedge pclk) disable iff (!presetn)
        !wr_matrix |=> wave_out_b_primary ==
            $past(output_ramp_matrix[PSF_MATRIX_B_LSB + ramp_num_2]))
    else $error("output B not from matrix");

    a_matrix_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !wr_matrix |=> wave_out_a_secondary ==
            $past(output_ramp_matrix[PSF_MATRIX_A_LSB + ramp_num_2]))
    else $error("output A not from matrix");

endmodule : psf_event_flags

// ==== tb/psf_wave_model.sv ====
// Far-side model: waveform generators of three controllers feeding the
// flag block. Assumes the bench calls its tasks from one process only.
module psf_wave_model
    import psf_pkg::*;
(
    input wire logic pclk,
    output logic [psf_pkg::PSF_UNITS-1:0] wave_out_0,
    output logic [psf_pkg::PSF_UNITS-1:0] wave_out_1,
    output logic [psf_pkg::PSF_UNITS-1:0] event_a,
    output logic [psf_pkg::PSF_UNITS-1:0] event_b,
    output logic [psf_pkg::PSF_UNITS-1:0] end_cycle,
    output logic [psf_pkg::PSF_UNITS-1:0] update,
    output logic [1:0] ramp_num_0,
    output logic [1:0] ramp_num_1,
    output logic [1:0] ramp_num_2
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        {wave_out_0, wave_out_1, event_a, event_b} = '0;
        {end_cycle, update, ramp_num_0, ramp_num_1, ramp_num_2} = '0;
    end

    // One-cycle pulse on the units in m; 0 ev A, 1 ev B, 2 cycle, 3 update
    task automatic pulse(input int kind, input logic [2:0] m);
        @(posedge pclk);
        case (kind)
            0: event_a <= m;
            1: event_b <= m;
            2: end_cycle <= m;
            default: update <= m;
        endcase
        @(posedge pclk);
        {event_a, event_b, end_cycle, update} <= '0;
    endtask : pulse

    task automatic toggle(input int side, input int u);
        @(posedge pclk);
        if (side == 1)
            wave_out_1[u] <= ~wave_out_1[u];
        else
            wave_out_0[u] <= ~wave_out_0[u];
    endtask : toggle

    task automatic set_ramp(input int u, input logic [1:0] r);
        @(posedge pclk);
        case (u)
            0: ramp_num_0 <= r;
            1: ramp_num_1 <= r;
            default: ramp_num_2 <= r;
        endcase
    endtask : set_ramp
endmodule : psf_wave_model

// ==== tb/psf_event_flags_tb.sv ====
// Bench for the event flag block: APB master tasks and one task per case.
// Assumes the far side is the wave model and a 20 MHz clock.
module psf_event_flags_tb
    import psf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [2:0] w0, w1, ea, eb, ec, up, unit_run, irq;
    logic [1:0] r0, r1, r2;
    logic a_pri, a_sec, b_pri, b_sec;
    int errors, cmp_count;

    psf_event_flags u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wave_out_0(w0), .wave_out_1(w1), .event_a(ea), .event_b(eb),
        .end_cycle(ec), .update(up), .ramp_num_0(r0), .ramp_num_1(r1),
        .ramp_num_2(r2), .unit_run(unit_run), .irq(irq),
        .wave_out_a_primary(a_pri), .wave_out_a_secondary(a_sec),
        .wave_out_b_primary(b_pri), .wave_out_b_secondary(b_sec));

    psf_wave_model u_gen (.pclk(pclk), .wave_out_0(w0), .wave_out_1(w1),
        .event_a(ea), .event_b(eb), .end_cycle(ec), .update(up),
        .ramp_num_0(r0), .ramp_num_1(r1), .ramp_num_2(r2));

    always #25 pclk = ~pclk;

    task automatic chk(input string n, input logic [31:0] seen,
        input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    // Request held until pready is sampled high; answer taken at that edge
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        chk("pready", {31'h0000_0000, pready}, 32'h0000_0001);
        q = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, {24'h00_0000, d}, q, e);
    endtask : wr

    task automatic rd_chk(input string n, input logic [7:0] a,
        input logic [7:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(n, q, {24'h00_0000, x});
        chk(n, {31'h0000_0000, e}, 32'h0000_0000);
    endtask : rd_chk

    task automatic irq_chk(input logic [2:0] x);
        @(negedge pclk);
        chk("irq", {29'h0000_0000, irq}, {29'h0000_0000, x});
    endtask : irq_chk

    task automatic t_reset_map;
        logic [31:0] q;
        logic e;
        rd_chk("matrix", PSF_ADDR_MATRIX, 8'h00);
        for (int u = 0; u < 3; u++)
        begin
            rd_chk("mask", PSF_ADDR_MASK0 + 8'(4 * u), 8'h00);
            rd_chk("flags", PSF_ADDR_FLAGS0 + 8'(4 * u), 8'h00);
            wr(PSF_ADDR_MASK0 + 8'(4 * u), 8'hFF);
            rd_chk("mask rw", PSF_ADDR_MASK0 + 8'(4 * u), 8'h39);
            wr(PSF_ADDR_MASK0 + 8'(4 * u), 8'h00);
        end
        irq_chk(3'b000);
        // A write without byte lane 0 is dropped
        pstrb <= 4'hE;
        wr(PSF_ADDR_MASK0, 8'h39);
        pstrb <= 4'hF;
        rd_chk("no strobe", PSF_ADDR_MASK0, 8'h00);
        // Unmapped word is refused and reads zero
        apb(1'b1, 8'h20, 32'h0000_00FF, q, e);
        apb(1'b0, 8'h20, 32'h0000_0000, q, e);
        chk("unmapped", {e, q[30:0]}, 32'h8000_0000);
    endtask : t_reset_map

    task automatic t_events;
        u_gen.set_ramp(1, 2'd2);
        u_gen.pulse(0, 3'b010);
        rd_chk("ev a", PSF_ADDR_FLAGS1, 8'h0C);
        irq_chk(3'b000);
        u_gen.set_ramp(1, 2'd3);
        u_gen.pulse(1, 3'b010);
        rd_chk("ev b", PSF_ADDR_FLAGS1, 8'h1E);
        wr(PSF_ADDR_FLAGS1, 8'h00);
        rd_chk("w0 keeps", PSF_ADDR_FLAGS1, 8'h1E);
        wr(PSF_ADDR_FLAGS1, 8'h08);
        rd_chk("w1 clears", PSF_ADDR_FLAGS1, 8'h16);
        wr(PSF_ADDR_FLAGS1, 8'hFF);
        rd_chk("ramp ro", PSF_ADDR_FLAGS1, 8'h06);
    endtask : t_events

    // Event A, event B and end of cycle, each enabled alone, raise only their own unit's line
    task automatic t_irq;
        int bitpos[3] = '{3, 4, 0};
        for (int u = 0; u < 3; u++)
            for (int k = 0; k < 3; k++)
            begin
                wr(PSF_ADDR_MASK0 + 8'(4 * u), 8'(1 << bitpos[k]));
                u_gen.pulse(k, 3'(1 << u));
                irq_chk(3'(1 << u));
                wr(PSF_ADDR_FLAGS0 + 8'(4 * u), 8'hFF);
                irq_chk(3'b000);
            end
        for (int u = 0; u < 3; u++)
            wr(PSF_ADDR_MASK0 + 8'(4 * u), 8'h00);
    endtask : t_irq

    task automatic t_activity;
        u_gen.toggle(0, 0);
        rd_chk("act a", PSF_ADDR_FLAGS0, 8'h40);
        u_gen.toggle(1, 0);
        u_gen.toggle(1, 0);
        rd_chk("act b", PSF_ADDR_FLAGS0, 8'hC0);
        wr(PSF_ADDR_FLAGS0, 8'hC0);
        rd_chk("act clr", PSF_ADDR_FLAGS0, 8'h00);
    endtask : t_activity

    task automatic t_sync;
        wr(PSF_ADDR_CTRL, 8'h10);
        repeat (3) @(posedge pclk);
        irq_chk(3'b000);
        chk("chain off", {29'h0000_0000, unit_run}, 32'h0000_0000);
        wr(PSF_ADDR_CTRL, 8'h11);
        // The follower must start on the same edge as its predecessor
        @(posedge pclk);
        irq_chk(3'b000);
        chk("chain", {29'h0000_0000, unit_run}, 32'h0000_0003);
        rd_chk("ctrl", PSF_ADDR_CTRL, 8'hD1);
        wr(PSF_ADDR_MASK1, 8'h20);
        u_gen.pulse(2, 3'b011);
        rd_chk("in step", PSF_ADDR_FLAGS1, 8'h07);
        u_gen.pulse(2, 3'b001);
        irq_chk(3'b010);
        rd_chk("skew eoc", PSF_ADDR_FLAGS1, 8'h27);
        rd_chk("no auto", PSF_ADDR_FLAGS0, 8'h01);
        wr(PSF_ADDR_FLAGS1, 8'h01);
        rd_chk("w0 sync", PSF_ADDR_FLAGS1, 8'h26);
        wr(PSF_ADDR_FLAGS1, 8'hFF);
        u_gen.pulse(3, 3'b010);
        rd_chk("skew upd", PSF_ADDR_FLAGS1, 8'h26);
        // Unit 0 follows unit 2 around the end of the chain
        wr(PSF_ADDR_CTRL, 8'h0C);
        u_gen.pulse(2, 3'b100);
        rd_chk("wrap", PSF_ADDR_FLAGS0, 8'h21);
        wr(PSF_ADDR_CTRL, 8'h00);
        wr(PSF_ADDR_MASK1, 8'h00);
    endtask : t_sync

    task automatic t_matrix;
        logic [7:0] m;
        m = 8'hA5;
        wr(PSF_ADDR_MATRIX, m);
        rd_chk("matrix rw", PSF_ADDR_MATRIX, m);
        for (int r = 0; r < 4; r++)
        begin
            u_gen.set_ramp(2, 2'(r));
            repeat (2) @(posedge pclk);
            @(negedge pclk);
            chk("out a", {30'h0000_0000, a_pri, a_sec},
                {30'h0000_0000, {2{m[r]}}});
            chk("out b", {30'h0000_0000, b_pri, b_sec},
                {30'h0000_0000, {2{m[4 + r]}}});
        end
    endtask : t_matrix

    task automatic print_verdict;
        if (errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    initial
    begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        errors = 0;
        cmp_count = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_map();
        t_events();
        t_irq();
        t_activity();
        t_sync();
        t_matrix();
        print_verdict();
    end

    // The whole sequence needs well under a thousand bus cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        print_verdict();
    end
endmodule : psf_event_flags_tb
